// ### logic/lane_ctrl_pkg.sv
// Constants and types for the lane control register bank.
// Assumes an 8-bit register port driven by the serial control port logic on the same clock.
`default_nettype none
package lane_ctrl_pkg;
  localparam int LANE_COUNT = 12;
  localparam int PAIR_COUNT = 6;
  localparam int REG_WIDTH = 8;

  typedef logic [REG_WIDTH-1:0] reg_byte_t;
  typedef logic [LANE_COUNT-1:0] lane_vec_t;
  typedef logic [PAIR_COUNT-1:0] pair_vec_t;

  // Register addresses
  localparam reg_byte_t SOFT_RESET_ADDR = 8'h00;
  localparam reg_byte_t TX_EN_LOW_ADDR = 8'h02;
  localparam reg_byte_t TX_EN_HIGH_ADDR = 8'h03;
  localparam reg_byte_t TX_REF_EN_ADDR = 8'h04;
  localparam reg_byte_t SQUELCH_CTRL_ADDR = 8'h05;
  localparam reg_byte_t RX_POL_LOW_ADDR = 8'h08;
  localparam reg_byte_t RX_POL_HIGH_ADDR = 8'h09;
  localparam reg_byte_t TX_POL_LOW_ADDR = 8'h0a;
  localparam reg_byte_t TX_POL_HIGH_ADDR = 8'h0b;

  // Reset values
  localparam reg_byte_t SOFT_RESET_RESET = 8'h00;
  localparam reg_byte_t TX_EN_LOW_RESET = 8'h00;
  localparam reg_byte_t TX_EN_HIGH_RESET = 8'h00;
  localparam reg_byte_t TX_REF_EN_RESET = 8'h3f;
  localparam reg_byte_t SQUELCH_CTRL_RESET = 8'h00;
  localparam reg_byte_t RX_POL_LOW_RESET = 8'h00;
  localparam reg_byte_t RX_POL_HIGH_RESET = 8'h00;
  localparam reg_byte_t TX_POL_LOW_RESET = 8'h00;
  localparam reg_byte_t TX_POL_HIGH_RESET = 8'h00;
  localparam reg_byte_t UNMAPPED_READ_VALUE = 8'h00;

  // Field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int GLOBAL_SQUELCH_BIT = 0;
  localparam int HIGH_LANE_BITS = 4;
  localparam int LOW_LANE_BITS = 8;
endpackage : lane_ctrl_pkg
`default_nettype wire

// ### logic/lane_sync.sv
// Two-flop synchroniser for lane pin levels.
// Assumes inputs arrive asynchronously from pins; only the second stage is read downstream.
`default_nettype none
module lane_sync #(
  parameter int WIDTH = 24
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : lane_sync
`default_nettype wire

// ### logic/lane_drive.sv
// Per-lane output stage: polarity swap, transmitter gating and squelch.
// Assumes synchronised pin levels and register fields on the same clock.
`default_nettype none
module lane_drive
  import lane_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire lane_vec_t rx_data_in,
  input wire lane_vec_t signal_loss_event_in,
  input wire lane_vec_t tx_data_in,
  input wire lane_vec_t tx_enable_in,
  input wire pair_vec_t pair_ref_on_in,
  input wire logic squelch_enable_in,
  input wire lane_vec_t rx_flip_in,
  input wire lane_vec_t tx_flip_in,
  output lane_vec_t rx_data_out,
  output lane_vec_t tx_data_out,
  output lane_vec_t tx_on_out,
  output lane_vec_t squelched_out
);
  genvar lane;
  generate
    for (lane = 0; lane < LANE_COUNT; lane++) begin : g_lane
      logic lane_on;
      logic lane_squelch;
      // A lane without its pair reference cannot drive, whatever its enable says
      assign lane_on = tx_enable_in[lane] & pair_ref_on_in[lane/2];
      assign lane_squelch = squelch_enable_in & signal_loss_event_in[lane];
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          rx_data_out[lane] <= 1'b0;
          tx_data_out[lane] <= 1'b0;
          tx_on_out[lane] <= 1'b0;
          squelched_out[lane] <= 1'b0;
        end else begin
          rx_data_out[lane] <= rx_data_in[lane] ^ rx_flip_in[lane];
          tx_data_out[lane] <= (tx_data_in[lane] ^ tx_flip_in[lane]) & lane_on & ~lane_squelch;
          tx_on_out[lane] <= lane_on;
          squelched_out[lane] <= lane_squelch;
        end
      end
    end
  endgenerate
endmodule : lane_drive
`default_nettype wire

// ### logic/lane_control_registers.sv
// Lane control register bank of a 12 lane crosspoint: enables, references, squelch, polarity.
// Assumes the serial control port decodes frames and presents one-cycle byte accesses on CLK_IN.
`default_nettype none
module lane_control_registers (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire lane_ctrl_pkg::reg_byte_t REG_ADDR_IN,
  input wire lane_ctrl_pkg::reg_byte_t REG_WDATA_IN,
  output lane_ctrl_pkg::reg_byte_t REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  output logic SOFT_RESET_PULSE_OUT,
  input wire lane_ctrl_pkg::lane_vec_t RX_DATA_IN,
  input wire lane_ctrl_pkg::lane_vec_t SIGNAL_LOSS_EVENT_IN,
  input wire lane_ctrl_pkg::lane_vec_t TX_DATA_IN,
  output lane_ctrl_pkg::lane_vec_t RX_DATA_OUT,
  output lane_ctrl_pkg::lane_vec_t TX_DATA_OUT,
  output lane_ctrl_pkg::lane_vec_t TX_OUTPUT_ON_OUT,
  output lane_ctrl_pkg::lane_vec_t SQUELCH_ACTIVE_OUT,
  output lane_ctrl_pkg::pair_vec_t TX_PAIR_REF_ON_OUT
);
  import lane_ctrl_pkg::*;

  reg_byte_t tx_output_enable_low_reg;
  reg_byte_t tx_output_enable_high_reg;
  reg_byte_t tx_pair_reference_enable_reg;
  reg_byte_t squelch_control_reg;
  reg_byte_t rx_polarity_low_reg;
  reg_byte_t rx_polarity_high_reg;
  reg_byte_t tx_polarity_low_reg;
  reg_byte_t tx_polarity_high_reg;
  reg_byte_t read_data_next;
  logic soft_reset_hit;
  logic restore_defaults;
  lane_vec_t tx_output_on_lanes;
  lane_vec_t rx_polarity_flip_lanes;
  lane_vec_t tx_polarity_flip_lanes;
  lane_vec_t rx_data_sync;
  lane_vec_t signal_loss_event_sync;

  // Only bit 0 matters; the strobe is never stored, so zero writes do nothing
  assign soft_reset_hit = REG_WR_IN && (REG_ADDR_IN == SOFT_RESET_ADDR) && REG_WDATA_IN[SOFT_RESET_BIT];
  assign restore_defaults = !RST_N_IN || soft_reset_hit;

  always_ff @(posedge CLK_IN) begin
    if (restore_defaults) begin
      tx_output_enable_low_reg <= TX_EN_LOW_RESET;
    end else if (REG_WR_IN && REG_ADDR_IN == TX_EN_LOW_ADDR) begin
      tx_output_enable_low_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (restore_defaults) begin
      tx_output_enable_high_reg <= TX_EN_HIGH_RESET;
    end else if (REG_WR_IN && REG_ADDR_IN == TX_EN_HIGH_ADDR) begin
      tx_output_enable_high_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (restore_defaults) begin
      tx_pair_reference_enable_reg <= TX_REF_EN_RESET;
    end else if (REG_WR_IN && REG_ADDR_IN == TX_REF_EN_ADDR) begin
      tx_pair_reference_enable_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (restore_defaults) begin
      squelch_control_reg <= SQUELCH_CTRL_RESET;
    end else if (REG_WR_IN && REG_ADDR_IN == SQUELCH_CTRL_ADDR) begin
      squelch_control_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (restore_defaults) begin
      rx_polarity_low_reg <= RX_POL_LOW_RESET;
    end else if (REG_WR_IN && REG_ADDR_IN == RX_POL_LOW_ADDR) begin
      rx_polarity_low_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (restore_defaults) begin
      rx_polarity_high_reg <= RX_POL_HIGH_RESET;
    end else if (REG_WR_IN && REG_ADDR_IN == RX_POL_HIGH_ADDR) begin
      rx_polarity_high_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (restore_defaults) begin
      tx_polarity_low_reg <= TX_POL_LOW_RESET;
    end else if (REG_WR_IN && REG_ADDR_IN == TX_POL_LOW_ADDR) begin
      tx_polarity_low_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (restore_defaults) begin
      tx_polarity_high_reg <= TX_POL_HIGH_RESET;
    end else if (REG_WR_IN && REG_ADDR_IN == TX_POL_HIGH_ADDR) begin
      tx_polarity_high_reg <= REG_WDATA_IN;
    end
  end

  // Lane vectors: high registers only carry lanes 11..8 in bits 3..0
  assign tx_output_on_lanes = {tx_output_enable_high_reg[HIGH_LANE_BITS-1:0],
                               tx_output_enable_low_reg[LOW_LANE_BITS-1:0]};
  assign rx_polarity_flip_lanes = {rx_polarity_high_reg[HIGH_LANE_BITS-1:0],
                                   rx_polarity_low_reg[LOW_LANE_BITS-1:0]};
  assign tx_polarity_flip_lanes = {tx_polarity_high_reg[HIGH_LANE_BITS-1:0],
                                   tx_polarity_low_reg[LOW_LANE_BITS-1:0]};

  // Read mux; unused bits of stored registers read back as written
  always_comb begin
    read_data_next = UNMAPPED_READ_VALUE;
    case (REG_ADDR_IN)
      SOFT_RESET_ADDR: read_data_next = SOFT_RESET_RESET;
      TX_EN_LOW_ADDR: read_data_next = tx_output_enable_low_reg;
      TX_EN_HIGH_ADDR: read_data_next = tx_output_enable_high_reg;
      TX_REF_EN_ADDR: read_data_next = tx_pair_reference_enable_reg;
      SQUELCH_CTRL_ADDR: read_data_next = squelch_control_reg;
      RX_POL_LOW_ADDR: read_data_next = rx_polarity_low_reg;
      RX_POL_HIGH_ADDR: read_data_next = rx_polarity_high_reg;
      TX_POL_LOW_ADDR: read_data_next = tx_polarity_low_reg;
      TX_POL_HIGH_ADDR: read_data_next = tx_polarity_high_reg;
      default: read_data_next = UNMAPPED_READ_VALUE;
    endcase
  end

  // A read in the same cycle as a write returns the value before the write
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      REG_RDATA_OUT <= UNMAPPED_READ_VALUE;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_RD_IN;
      if (REG_RD_IN) begin
        REG_RDATA_OUT <= read_data_next;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      SOFT_RESET_PULSE_OUT <= 1'b0;
    end else begin
      SOFT_RESET_PULSE_OUT <= soft_reset_hit;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      TX_PAIR_REF_ON_OUT <= '0;
    end else begin
      TX_PAIR_REF_ON_OUT <= tx_pair_reference_enable_reg[PAIR_COUNT-1:0];
    end
  end

  // Pin levels are asynchronous to CLK_IN
  lane_sync #(
    .WIDTH(2 * LANE_COUNT)
  ) u_pin_sync (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .async_in({SIGNAL_LOSS_EVENT_IN, RX_DATA_IN}),
    .sync_out({signal_loss_event_sync, rx_data_sync})
  );

  lane_drive u_lane_drive (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .rx_data_in(rx_data_sync),
    .signal_loss_event_in(signal_loss_event_sync),
    .tx_data_in(TX_DATA_IN),
    .tx_enable_in(tx_output_on_lanes),
    .pair_ref_on_in(tx_pair_reference_enable_reg[PAIR_COUNT-1:0]),
    .squelch_enable_in(squelch_control_reg[GLOBAL_SQUELCH_BIT]),
    .rx_flip_in(rx_polarity_flip_lanes),
    .tx_flip_in(tx_polarity_flip_lanes),
    .rx_data_out(RX_DATA_OUT),
    .tx_data_out(TX_DATA_OUT),
    .tx_on_out(TX_OUTPUT_ON_OUT),
    .squelched_out(SQUELCH_ACTIVE_OUT)
  );

  property p_soft_reset_defaults;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    soft_reset_hit |=> (tx_output_enable_low_reg == TX_EN_LOW_RESET) &&
      (tx_pair_reference_enable_reg == TX_REF_EN_RESET) && (squelch_control_reg == SQUELCH_CTRL_RESET) &&
      (tx_polarity_high_reg == TX_POL_HIGH_RESET) ##1 (TX_OUTPUT_ON_OUT == '0);
  endproperty
  a_soft_reset_defaults: assert property (p_soft_reset_defaults)
    else $error("soft reset did not restore defaults");

  property p_reset_reg_reads_zero;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (REG_RD_IN && REG_ADDR_IN == SOFT_RESET_ADDR) |=> REG_RVALID_OUT && (REG_RDATA_OUT == 8'h00);
  endproperty
  a_reset_reg_reads_zero: assert property (p_reset_reg_reads_zero)
    else $error("reset register read not zero");

  property p_zero_strobe_no_effect;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (REG_WR_IN && REG_ADDR_IN == SOFT_RESET_ADDR && !REG_WDATA_IN[SOFT_RESET_BIT])
      |=> $stable(tx_pair_reference_enable_reg) && $stable(rx_polarity_low_reg) && !SOFT_RESET_PULSE_OUT;
  endproperty
  a_zero_strobe_no_effect: assert property (p_zero_strobe_no_effect)
    else $error("zero write to reset register had effect");

  property p_tx_enable_low_write;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (REG_WR_IN && REG_ADDR_IN == TX_EN_LOW_ADDR && REG_WDATA_IN[0] && tx_pair_reference_enable_reg[0])
      |=> tx_output_enable_low_reg[0] ##1 TX_OUTPUT_ON_OUT[0];
  endproperty
  a_tx_enable_low_write: assert property (p_tx_enable_low_write)
    else $error("lane 0 transmitter did not turn on");

  property p_tx_enable_off;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (REG_WR_IN && REG_ADDR_IN == TX_EN_HIGH_ADDR && !REG_WDATA_IN[3]) |=> ##1 !TX_OUTPUT_ON_OUT[11];
  endproperty
  a_tx_enable_off: assert property (p_tx_enable_off)
    else $error("lane 11 transmitter did not turn off");

  property p_tx_enable_high_readback;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (REG_WR_IN && REG_ADDR_IN == TX_EN_HIGH_ADDR) ##1 (REG_RD_IN && REG_ADDR_IN == TX_EN_HIGH_ADDR && !REG_WR_IN)
      |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2);
  endproperty
  a_tx_enable_high_readback: assert property (p_tx_enable_high_readback)
    else $error("high enable register read back wrong");

  property p_ref_reset_value;
    @(posedge CLK_IN)
    !RST_N_IN |=> tx_pair_reference_enable_reg == TX_REF_EN_RESET;
  endproperty
  a_ref_reset_value: assert property (p_ref_reset_value)
    else $error("reference enable reset value wrong");

  property p_ref_pair_map;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !tx_pair_reference_enable_reg[5] |=> !TX_OUTPUT_ON_OUT[10] && !TX_OUTPUT_ON_OUT[11] && !TX_PAIR_REF_ON_OUT[5];
  endproperty
  a_ref_pair_map: assert property (p_ref_pair_map)
    else $error("pair reference off but lane 10 or 11 on");

  property p_squelch;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (squelch_control_reg[GLOBAL_SQUELCH_BIT] && signal_loss_event_sync[2]) |=> !TX_DATA_OUT[2] && SQUELCH_ACTIVE_OUT[2];
  endproperty
  a_squelch: assert property (p_squelch)
    else $error("lane 2 not squelched on signal loss");

  property p_rx_polarity;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    1'b1 |=> RX_DATA_OUT == ($past(rx_data_sync) ^ $past(rx_polarity_flip_lanes));
  endproperty
  a_rx_polarity: assert property (p_rx_polarity)
    else $error("receive polarity mismatch");

  property p_tx_polarity;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (TX_OUTPUT_ON_OUT[9] && !SQUELCH_ACTIVE_OUT[9] && $past(TX_OUTPUT_ON_OUT[9]))
      |-> TX_DATA_OUT[9] == ($past(TX_DATA_IN[9]) ^ $past(tx_polarity_flip_lanes[9]));
  endproperty
  a_tx_polarity: assert property (p_tx_polarity)
    else $error("transmit lane 9 polarity mismatch");

  property p_polarity_reset;
    @(posedge CLK_IN)
    !RST_N_IN |=> (rx_polarity_flip_lanes == '0) && (tx_polarity_flip_lanes == '0) ##1 (RX_DATA_OUT == $past(rx_data_sync));
  endproperty
  a_polarity_reset: assert property (p_polarity_reset)
    else $error("polarity not cleared by reset");

  property p_soft_reset_pulse;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    1'b1 |=> SOFT_RESET_PULSE_OUT == $past(soft_reset_hit);
  endproperty
  a_soft_reset_pulse: assert property (p_soft_reset_pulse)
    else $error("reset strobe pulse wrong");

  property p_tx_enable_high_write;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (REG_WR_IN && REG_ADDR_IN == TX_EN_HIGH_ADDR && REG_WDATA_IN[3] && tx_pair_reference_enable_reg[5])
      |=> tx_output_enable_high_reg[3] ##1 TX_OUTPUT_ON_OUT[11];
  endproperty
  a_tx_enable_high_write: assert property (p_tx_enable_high_write)
    else $error("lane 11 transmitter did not turn on");

  property p_tx_off_quiet;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !tx_output_on_lanes[4] |=> !TX_OUTPUT_ON_OUT[4] && !TX_DATA_OUT[4];
  endproperty
  a_tx_off_quiet: assert property (p_tx_off_quiet)
    else $error("disabled lane 4 still driving");

  property p_ref_pair_low;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !tx_pair_reference_enable_reg[0]
      |=> !TX_OUTPUT_ON_OUT[0] && !TX_OUTPUT_ON_OUT[1] && !TX_PAIR_REF_ON_OUT[0];
  endproperty
  a_ref_pair_low: assert property (p_ref_pair_low)
    else $error("pair reference off but lane 0 or 1 on");

  property p_squelch_off;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !squelch_control_reg[GLOBAL_SQUELCH_BIT] |=> SQUELCH_ACTIVE_OUT == '0;
  endproperty
  a_squelch_off: assert property (p_squelch_off)
    else $error("squelch active while disabled");

  property p_rx_high_flip;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    rx_polarity_high_reg[3] |=> RX_DATA_OUT[11] == !$past(rx_data_sync[11]);
  endproperty
  a_rx_high_flip: assert property (p_rx_high_flip)
    else $error("receive lane 11 not inverted");

  property p_tx_pass_plain;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (!tx_polarity_flip_lanes[3] && tx_output_on_lanes[3] && tx_pair_reference_enable_reg[1] &&
      !(squelch_control_reg[GLOBAL_SQUELCH_BIT] && signal_loss_event_sync[3]))
      |=> TX_DATA_OUT[3] == $past(TX_DATA_IN[3]);
  endproperty
  a_tx_pass_plain: assert property (p_tx_pass_plain)
    else $error("transmit lane 3 not passed noninverted");
endmodule : lane_control_registers
`default_nettype wire

// ### dv/host_model.sv
// Host model: drives the lane register port with write bursts and reads.
// Assumes every call starts just after a rising edge of clk_in.
`default_nettype none
module host_model
  import lane_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire reg_byte_t rdata_in,
  input wire logic rvalid_in,
  output logic wr_out,
  output logic rd_out,
  output reg_byte_t addr_out,
  output reg_byte_t wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap = 0;
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h5a;
    wdata_out = 8'ha5;
  end
  // With a nonzero gap, released lines flip so a stale address never looks valid
  task automatic idle();
    if (gap > 0) begin
      addr_out = ~addr_out;
      wdata_out = ~wdata_out;
    end
    repeat (gap) begin
      @(posedge clk_in);
      #1;
    end
  endtask : idle
  task automatic write_burst(input reg_byte_t a[$], input reg_byte_t d[$]);
    foreach (a[i]) begin
      wr_out = 1'b1;
      addr_out = a[i];
      wdata_out = d[i];
      @(posedge clk_in);
      #1;
    end
    wr_out = 1'b0;
    idle();
  endtask : write_burst
  task automatic read_reg(input reg_byte_t a, output reg_byte_t d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    rd_out = 1'b1;
    addr_out = a;
    for (int k = 0; k < 4 && !ok; k++) begin
      @(posedge clk_in);
      #1;
      rd_out = 1'b0;
      if (rvalid_in === 1'b1) begin
        d = rdata_in;
        ok = 1'b1;
      end
    end
    // One quiet edge so two reads never touch the strobe in one step
    @(posedge clk_in);
    #1;
    idle();
  endtask : read_reg
endmodule : host_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench: lane control registers against an integer model.
// Assumes host_model drives the register port; lane pins are driven here.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lane_ctrl_pkg::*;
  logic clk, rst_n, wr, rd, rvalid, pulse;
  reg_byte_t addr, wdata, rdata, rd_got;
  lane_vec_t rx_in, loss_in, tx_in, rx_out, tx_out, on_out, sq_out;
  pair_vec_t ref_out;
  int m[16];
  int bad_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'hc4a7f2da;
  bit ok;
  reg_byte_t qa[$], qd[$];
  lane_control_registers i_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .SOFT_RESET_PULSE_OUT(pulse), .RX_DATA_IN(rx_in), .SIGNAL_LOSS_EVENT_IN(loss_in),
    .TX_DATA_IN(tx_in), .RX_DATA_OUT(rx_out), .TX_DATA_OUT(tx_out), .TX_OUTPUT_ON_OUT(on_out),
    .SQUELCH_ACTIVE_OUT(sq_out), .TX_PAIR_REF_ON_OUT(ref_out));
  host_model i_host (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .wr_out(wr),
    .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic int rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return int'(seed);
  endfunction : rnd
  function automatic void model_write(input int a, input int d);
    if (a == 0 && d[0]) begin
      foreach (m[i]) m[i] = 0;
      m[4] = 'h3f;
    end else if (a inside {2, 3, 4, 5, 8, 9, 10, 11}) begin
      m[a] = d & 'hff;
    end
  endfunction : model_write
  task automatic tally_and_finish();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic note(input bit bad, input string what);
    samples_checked++;
    if (bad) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : note
  task automatic chk_reg(input reg_byte_t got, input reg_byte_t exp);
    note(got !== exp, $sformatf("register read %h, expected %h", got, exp));
  endtask : chk_reg
  task automatic chk_lane(input lane_vec_t got, input lane_vec_t exp);
    note(got !== exp, $sformatf("lane vector %h, expected %h", got, exp));
  endtask : chk_lane
  task automatic chk_bit(input logic got, input logic exp);
    note(got !== exp, $sformatf("reset strobe %b, expected %b", got, exp));
  endtask : chk_bit
  task automatic put(input int a, input int d);
    qa.push_back(reg_byte_t'(a));
    qd.push_back(reg_byte_t'(d));
    model_write(a, d);
  endtask : put
  task automatic flush();
    i_host.write_burst(qa, qd);
    qa.delete();
    qd.delete();
  endtask : flush
  // Pin synchronisers and the lane output stage need three edges, so six leaves margin
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask : settle
  task automatic read_chk(input int a);
    i_host.read_reg(reg_byte_t'(a), rd_got, ok);
    if (!ok) begin
      note(1'b1, "read answer missing");
      tally_and_finish();
    end else begin
      chk_reg(rd_got, reg_byte_t'(m[a]));
    end
  endtask : read_chk
  task automatic check_regs();
    for (int a = 0; a < 16; a++) begin
      read_chk(a);
    end
  endtask : check_regs
  task automatic check_lanes();
    lane_vec_t ten, on, sq;
    ten = lane_vec_t'((m[3] << 8) | m[2]);
    on = 12'h000;
    for (int n = 0; n < 12; n++) begin
      on[n] = ten[n] & m[4][n / 2];
    end
    sq = m[5][0] ? loss_in : 12'h000;
    chk_lane(on_out, on);
    chk_lane({6'h00, ref_out}, lane_vec_t'(m[4] & 'h3f));
    chk_lane(sq_out, sq);
    chk_lane(rx_out, rx_in ^ lane_vec_t'((m[9] << 8) | m[8]));
    chk_lane(tx_out, (tx_in ^ lane_vec_t'((m[11] << 8) | m[10])) & on & ~sq);
  endtask : check_lanes
  initial begin
    rst_n = 1'b0;
    rx_in = 12'h000;
    loss_in = 12'h000;
    tx_in = 12'hfff;
    model_write(0, 1);
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    settle();
    check_regs();
    check_lanes();
    // Walk each transmitter enable, then each pair reference
    for (int n = 0; n < 12; n++) begin
      put(2, n < 8 ? 1 << n : 0);
      put(3, n < 8 ? 0 : 1 << (n - 8));
      flush();
      read_chk(3);
      settle();
      check_lanes();
    end
    put(2, 'hff);
    put(3, 'h0f);
    for (int p = 0; p < 6; p++) begin
      put(4, 1 << p);
      flush();
      settle();
      check_lanes();
    end
    // Random bursts with a host that is sometimes slow
    for (int it = 0; it < 24; it++) begin
      i_host.gap = it % 3;
      for (int k = 0; k < 3; k++) begin
        put(rnd() & 'hf, rnd() & 'hff);
      end
      flush();
      rx_in = lane_vec_t'(rnd());
      tx_in = lane_vec_t'(rnd());
      loss_in = lane_vec_t'(rnd());
      settle();
      check_lanes();
      check_regs();
    end
    i_host.gap = 0;
    for (int a = 2; a < 12; a++) begin
      put(a, 'hff);
    end
    put(0, 'hfe);
    flush();
    chk_bit(pulse, 1'b0);
    settle();
    check_regs();
    put(0, 'h01);
    flush();
    chk_bit(pulse, 1'b1);
    @(posedge clk);
    #1;
    chk_bit(pulse, 1'b0);
    settle();
    check_regs();
    check_lanes();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
